// ---- design/exrq_slave.sv ----
`timescale 1ns/1ns
module exrq_slave
  import exrq_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // System bus pins
  input wire logic grant_n_i,
  input wire logic valid_n_i,
  input wire logic [CMD_W-1:0] command_bus_i,
  input wire logic [AD_W-1:0] addr_data_bus_i,
  input wire logic response_valid_n_i,
  input wire logic [RESP_W-1:0] response_bus_i,
  output logic release_n_o,
  // Internal handoff: the core wants the bus back
  input wire logic own_request_i,
  // Decoded request towards the core
  output logic req_valid_o,
  output logic req_coherent_o,
  output logic [2:0] req_op_o,
  output logic [RN_W-1:0] req_rn_o,
  output logic [3:0] req_target_o,
  output logic [PADDR_W-1:0] req_addr_o,
  output logic req_ecc_o,
  output logic [1:0] req_cause_o,
  // State towards the core
  output logic [INT_W-1:0] int_bits_o,
  output logic [RN_CNT-1:0] rn_reserved_o,
  output logic [RN_CNT-1:0] rn_coh_busy_o,
  output logic slave_state_o
);
  // Pin synchronisers
  logic gnt_s1_r, gnt_s2_r, val_s1_r, val_s2_r, rv_s1_r, rv_s2_r;
  logic [CMD_W-1:0] cmd_s1_r, cmd_s2_r;
  logic [AD_W-1:0] ad_s1_r, ad_s2_r;
  logic [RESP_W-1:0] rsp_s1_r, rsp_s2_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // Grant idles asserted in master state; a negated reset value would fake a handoff
      gnt_s1_r <= 1'b0;
      gnt_s2_r <= 1'b0;
      val_s1_r <= 1'b1;
      val_s2_r <= 1'b1;
      rv_s1_r <= 1'b1;
      rv_s2_r <= 1'b1;
      cmd_s1_r <= '0;
      cmd_s2_r <= '0;
      ad_s1_r <= '0;
      ad_s2_r <= '0;
      rsp_s1_r <= '0;
      rsp_s2_r <= '0;
    end else begin
      gnt_s1_r <= grant_n_i;
      gnt_s2_r <= gnt_s1_r;
      val_s1_r <= valid_n_i;
      val_s2_r <= val_s1_r;
      rv_s1_r <= response_valid_n_i;
      rv_s2_r <= rv_s1_r;
      cmd_s1_r <= command_bus_i;
      cmd_s2_r <= cmd_s1_r;
      ad_s1_r <= addr_data_bus_i;
      ad_s2_r <= ad_s1_r;
      rsp_s1_r <= response_bus_i;
      rsp_s2_r <= rsp_s1_r;
    end
  end

  // Bus ownership handoff
  exrq_bus_t bus_r, bus_nxt;
  logic rel_n_r, rel_n_nxt, slave_r, slave_nxt;

  always_comb begin
    bus_nxt = bus_r;
    rel_n_nxt = 1'b1;
    case (bus_r)
      BUS_MASTER: begin
        if (gnt_s2_r) begin
          bus_nxt = BUS_RELEASE;
        end
      end
      BUS_RELEASE: begin
        rel_n_nxt = 1'b0;
        bus_nxt = BUS_SLAVE;
      end
      BUS_SLAVE: begin
        if (own_request_i && !gnt_s2_r) begin
          bus_nxt = BUS_MASTER;
        end
      end
      default: begin
        bus_nxt = BUS_MASTER;
      end
    endcase
    slave_nxt = (bus_nxt == BUS_SLAVE);
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_r <= BUS_MASTER;
      rel_n_r <= 1'b1;
      slave_r <= 1'b0;
    end else begin
      bus_r <= bus_nxt;
      rel_n_r <= rel_n_nxt;
      slave_r <= slave_nxt;
    end
  end

  // Request decode; only address cycles in slave state count
  logic in_slave, addr_cyc;
  logic [2:0] op;
  logic [RN_W-1:0] rn;
  logic is_coh, is_alloc, is_int;
  assign in_slave = (bus_r == BUS_SLAVE);
  assign addr_cyc = in_slave && !val_s2_r && !cmd_s2_r[CMD_DATA_BIT];
  assign op = cmd_s2_r[CMD_OP_HI:CMD_OP_LO];
  assign rn = cmd_s2_r[CMD_RN_HI:CMD_RN_LO];
  assign is_coh = addr_cyc && (op == OP_INTERVENE || op == OP_INVALIDATE);
  assign is_alloc = addr_cyc && (op == OP_ALLOCATE);
  assign is_int = addr_cyc && (op == OP_SPECIAL);

  logic rsp_fire;
  logic [RN_W-1:0] rsp_rn;
  assign rsp_fire = !rv_s2_r;
  assign rsp_rn = rsp_s2_r[RESP_RN_HI:RESP_RN_LO];

  // Outstanding coherency and allocate numbers, eight of each
  logic [RN_CNT-1:0] coh_busy, alloc_busy;
  exrq_rn_track u_coh (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .set_i(is_coh),
    .set_rn_i(rn),
    .free_i(rsp_fire),
    .free_rn_i(rsp_rn),
    .busy_o(coh_busy)
  );
  exrq_rn_track u_alloc (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .set_i(is_alloc),
    .set_rn_i(rn),
    .free_i(rsp_fire),
    .free_rn_i(rsp_rn),
    .busy_o(alloc_busy)
  );

  // Registered request outputs and interrupt bits
  logic val_r, val_nxt, coh_r, coh_nxt, ecc_r, ecc_nxt;
  logic [2:0] op_r, op_nxt;
  logic [RN_W-1:0] rn_r, rn_nxt;
  logic [3:0] tgt_r, tgt_nxt;
  logic [PADDR_W-1:0] addr_r, addr_nxt;
  logic [1:0] cause_r, cause_nxt;
  logic [INT_W-1:0] int_r, int_nxt;
  logic [INT_W-1:0] wen;
  logic [INT_W-1:0] wval;
  assign wen = ad_s2_r[AD_WEN_HI:AD_WEN_LO];
  assign wval = ad_s2_r[AD_IVAL_HI:0];

  always_comb begin
    val_nxt = addr_cyc; // every cycle may accept
    coh_nxt = is_coh;
    op_nxt = op;
    rn_nxt = rn;
    tgt_nxt = ad_s2_r[AD_TGT_HI:AD_TGT_LO];
    addr_nxt = ad_s2_r[AD_ADDR_HI:0];
    ecc_nxt = cmd_s2_r[CMD_ECC_BIT];
    cause_nxt = cmd_s2_r[CMD_CAUSE_HI:CMD_CAUSE_LO];
    int_nxt = int_r;
    if (is_int) begin
      int_nxt = (int_r & ~wen) | (wval & wen);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      val_r <= 1'b0;
      coh_r <= 1'b0;
      op_r <= 3'h0;
      rn_r <= '0;
      tgt_r <= TGT_RST;
      addr_r <= '0;
      ecc_r <= 1'b0;
      cause_r <= 2'h0;
      int_r <= INT_RST;
    end else begin
      val_r <= val_nxt;
      coh_r <= coh_nxt;
      op_r <= op_nxt;
      rn_r <= rn_nxt;
      tgt_r <= tgt_nxt;
      addr_r <= addr_nxt;
      ecc_r <= ecc_nxt;
      cause_r <= cause_nxt;
      int_r <= int_nxt;
    end
  end

  assign release_n_o = rel_n_r;
  assign req_valid_o = val_r;
  assign req_coherent_o = coh_r;
  assign req_op_o = op_r;
  assign req_rn_o = rn_r;
  assign req_target_o = tgt_r;
  assign req_addr_o = addr_r;
  assign req_ecc_o = ecc_r;
  assign req_cause_o = cause_r;
  assign int_bits_o = int_r;
  assign rn_reserved_o = alloc_busy;
  assign rn_coh_busy_o = coh_busy;
  assign slave_state_o = slave_r;

  // Checks
  sequence s_handoff;
    bus_r == BUS_MASTER && gnt_s2_r ##1 bus_r == BUS_RELEASE;
  endsequence
  property p_release;
    @(posedge clock_i) disable iff (!nrst_i) s_handoff |=> !release_n_o;
  endproperty
  a_release: assert property (p_release) else $error("release not asserted after grant negated");
  property p_coh;
    @(posedge clock_i) disable iff (!nrst_i) is_coh |=> req_valid_o && req_coherent_o;
  endproperty
  a_coh: assert property (p_coh) else $error("coherency request not flagged");
  property p_nocoh;
    @(posedge clock_i) disable iff (!nrst_i) (is_alloc || is_int) |=> !req_coherent_o;
  endproperty
  a_nocoh: assert property (p_nocoh) else $error("non-coherency request flagged");
  property p_b2b;
    @(posedge clock_i) disable iff (!nrst_i) addr_cyc ##1 addr_cyc |-> req_valid_o ##1 req_valid_o;
  endproperty
  a_b2b: assert property (p_b2b) else $error("back-to-back request dropped");
  property p_alloc;
    @(posedge clock_i) disable iff (!nrst_i) is_alloc |-> ##2 rn_reserved_o[$past(rn, 2)];
  endproperty
  a_alloc: assert property (p_alloc) else $error("allocated number not reserved");
  property p_free;
    @(posedge clock_i) disable iff (!nrst_i) rsp_fire && !is_alloc |-> ##2 !rn_reserved_o[$past(rsp_rn, 2)];
  endproperty
  a_free: assert property (p_free) else $error("completion did not free number");
  property p_intr;
    @(posedge clock_i) disable iff (!nrst_i)
      is_int |=> int_bits_o == (($past(int_r) & ~$past(wen)) | ($past(wval) & $past(wen)));
  endproperty
  a_intr: assert property (p_intr) else $error("interrupt bits wrong");
  property p_master;
    @(posedge clock_i) disable iff (!nrst_i) !in_slave |=> !req_valid_o;
  endproperty
  a_master: assert property (p_master) else $error("request taken in master state");
endmodule : exrq_slave

// ---- design/exrq_pkg.sv ----
package exrq_pkg;
  // Command bus field layout
  localparam int CMD_W = 12;
  localparam int CMD_DATA_BIT = 11;
  localparam int CMD_RN_HI = 10;
  localparam int CMD_RN_LO = 8;
  localparam int CMD_OP_HI = 7;
  localparam int CMD_OP_LO = 5;
  localparam int CMD_CAUSE_HI = 4;
  localparam int CMD_CAUSE_LO = 3;
  localparam int CMD_ECC_BIT = 0;
  // Address/data bus field layout
  localparam int AD_W = 64;
  localparam int AD_TGT_HI = 63;
  localparam int AD_TGT_LO = 60;
  localparam int AD_ADDR_HI = 39;
  localparam int AD_WEN_HI = 20;
  localparam int AD_WEN_LO = 16;
  localparam int AD_IVAL_HI = 4;
  localparam int PADDR_W = 40;
  localparam int INT_W = 5;
  // Request numbers and response bus
  localparam int RN_W = 3;
  localparam int RN_CNT = 8;
  localparam int RESP_W = 5;
  localparam int RESP_RN_HI = 4;
  localparam int RESP_RN_LO = 2;
  // Command codes; values chosen for this block
  localparam logic [2:0] OP_INTERVENE = 3'h0;
  localparam logic [2:0] OP_ALLOCATE = 3'h1;
  localparam logic [2:0] OP_INVALIDATE = 3'h2;
  localparam logic [2:0] OP_SPECIAL = 3'h3;
  // Reset values
  localparam logic [RN_CNT-1:0] BUSY_RST = 8'h00;
  localparam logic [INT_W-1:0] INT_RST = 5'h00;
  localparam logic [3:0] TGT_RST = 4'h0;

  typedef enum logic [1:0] {
    BUS_MASTER = 2'b00,
    BUS_RELEASE = 2'b01,
    BUS_SLAVE = 2'b11
  } exrq_bus_t;
endpackage : exrq_pkg

// ---- design/exrq_rn_track.sv ----
`timescale 1ns/1ns
module exrq_rn_track
  import exrq_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Set and free strobes
  input wire logic set_i,
  input wire logic [RN_W-1:0] set_rn_i,
  input wire logic free_i,
  input wire logic [RN_W-1:0] free_rn_i,
  // Tracked numbers
  output logic [RN_CNT-1:0] busy_o
);
  logic [RN_CNT-1:0] busy_r;
  logic [RN_CNT-1:0] busy_nxt;

  // Setting wins when the same number is freed in that cycle
  always_comb begin
    busy_nxt = busy_r;
    if (free_i) begin
      busy_nxt[free_rn_i] = 1'b0;
    end
    if (set_i) begin
      busy_nxt[set_rn_i] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_r <= BUSY_RST;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  assign busy_o = busy_r;
endmodule : exrq_rn_track

// ---- sim/exrq_agent.sv ----
`timescale 1ns/1ns
module exrq_agent
  import exrq_pkg::*;
(
  // Clock and handoff
  input wire logic clock_i,
  input wire logic release_n_i,
  output logic grant_n_o,
  // Request and completion pins
  output logic valid_n_o,
  output logic [CMD_W-1:0] command_bus_o,
  output logic [AD_W-1:0] addr_data_bus_o,
  output logic response_valid_n_o,
  output logic [RESP_W-1:0] response_bus_o
);
  int outstanding = 0;
  initial begin
    grant_n_o = 1'b0;
    valid_n_o = 1'b1;
    command_bus_o = 12'hFFF;
    addr_data_bus_o = 64'h0;
    response_valid_n_o = 1'b1;
    response_bus_o = 5'h00;
  end
  // Negate grant, then watch 12 falling edges for the release pulse before any request
  task automatic take_bus(output bit ok);
    ok = 1'b0;
    @(posedge clock_i);
    grant_n_o <= 1'b1;
    repeat (12) begin
      @(negedge clock_i);
      if (release_n_i === 1'b0) ok = 1'b1;
    end
  endtask : take_bus
  task automatic give_bus();
    @(posedge clock_i);
    grant_n_o <= 1'b0;
  endtask : give_bus
  // One address cycle; numbered requests are counted and going over the limit is only reported
  task automatic send(input logic [CMD_W-1:0] cmd, input logic [AD_W-1:0] ad);
    if (cmd[7:5] != OP_SPECIAL) outstanding++;
    if (outstanding > RN_CNT) $display("agent over the outstanding limit");
    @(posedge clock_i);
    valid_n_o <= 1'b0;
    command_bus_o <= cmd;
    addr_data_bus_o <= ad;
  endtask : send
  // Released lines show the inverse of their last value
  task automatic idle();
    @(posedge clock_i);
    valid_n_o <= 1'b1;
    command_bus_o <= ~command_bus_o;
    addr_data_bus_o <= ~addr_data_bus_o;
  endtask : idle
  task automatic complete(input logic [RN_W-1:0] rn, input logic [1:0] kind);
    outstanding--;
    @(posedge clock_i);
    response_valid_n_o <= 1'b0;
    response_bus_o <= {rn, kind};
    @(posedge clock_i);
    response_valid_n_o <= 1'b1;
    response_bus_o <= ~response_bus_o;
  endtask : complete
endmodule : exrq_agent

// ---- sim/exrq_slave_bench.sv ----
`timescale 1ns/1ns
module exrq_slave_bench
  import exrq_pkg::*;
;
  logic clock_i, nrst_i, grant_n, valid_n, rsp_val_n, rel_n, own_req, req_valid, req_coh, req_ecc;
  logic [CMD_W-1:0] cmd;
  logic [AD_W-1:0] ad;
  logic [RESP_W-1:0] rsp;
  logic [2:0] req_op;
  logic [RN_W-1:0] req_rn;
  logic [3:0] req_tgt;
  logic [PADDR_W-1:0] req_addr;
  logic [1:0] req_cause;
  logic [INT_W-1:0] int_bits;
  logic [RN_CNT-1:0] rn_res, rn_coh;
  logic slave;
  int bad_count = 0;
  int total_checks = 0;
  bit ok;
  typedef struct packed {logic [2:0] op; logic [2:0] rn; logic [3:0] tgt; logic ecc; logic [1:0] cause;
    logic [39:0] low; logic coh;} exrq_row_t;
  exrq_row_t rows[4] = '{
    '{OP_INTERVENE, 3'h3, 4'hA, 1'b1, 2'h0, 40'h12_3456_789A, 1'b1},
    '{OP_INVALIDATE, 3'h7, 4'h5, 1'b0, 2'h0, 40'hFF_FFFF_FFFF, 1'b1},
    '{OP_ALLOCATE, 3'h0, 4'h0, 1'b0, 2'h0, 40'h0, 1'b0},
    '{OP_SPECIAL, 3'h0, 4'h9, 1'b1, 2'h2, 40'h00_0015_001F, 1'b0}};

  exrq_slave dut (.clock_i(clock_i), .nrst_i(nrst_i), .grant_n_i(grant_n), .valid_n_i(valid_n),
    .command_bus_i(cmd), .addr_data_bus_i(ad), .response_valid_n_i(rsp_val_n), .response_bus_i(rsp),
    .release_n_o(rel_n), .own_request_i(own_req), .req_valid_o(req_valid), .req_coherent_o(req_coh),
    .req_op_o(req_op), .req_rn_o(req_rn), .req_target_o(req_tgt), .req_addr_o(req_addr),
    .req_ecc_o(req_ecc), .req_cause_o(req_cause), .int_bits_o(int_bits), .rn_reserved_o(rn_res),
    .rn_coh_busy_o(rn_coh), .slave_state_o(slave));
  exrq_agent agent (.clock_i(clock_i), .release_n_i(rel_n), .grant_n_o(grant_n), .valid_n_o(valid_n),
    .command_bus_o(cmd), .addr_data_bus_o(ad), .response_valid_n_o(rsp_val_n), .response_bus_o(rsp));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [CMD_W-1:0] mk_cmd(input exrq_row_t r);
    return {1'b0, r.rn, r.op, r.cause, 2'b00, r.ecc};
  endfunction : mk_cmd
  task automatic wait_req();
    int n;
    n = 0;
    @(negedge clock_i);
    while (req_valid !== 1'b1 && n < 8) begin
      @(negedge clock_i);
      n++;
    end
    chk(req_valid, 1'b1);
  endtask : wait_req

  initial begin
    #(3000 * 100);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    nrst_i = 1'b0;
    own_req = 1'b0;
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    chk({rel_n, slave, int_bits, rn_res, rn_coh}, {1'b1, 1'b0, 21'h0});
    agent.take_bus(ok);
    chk(ok, 1'b1);
    chk(slave, 1'b1);
    foreach (rows[i]) begin
      agent.send(mk_cmd(rows[i]), {rows[i].tgt, 20'h0, rows[i].low});
      agent.idle();
      wait_req();
      chk({req_op, req_coh, req_tgt, req_ecc}, {rows[i].op, rows[i].coh, rows[i].tgt, rows[i].ecc});
      if (rows[i].coh) chk({req_rn, req_addr}, {rows[i].rn, rows[i].low});
      if (rows[i].op == OP_ALLOCATE) chk(req_rn, rows[i].rn);
      if (rows[i].op == OP_SPECIAL) chk(req_cause, rows[i].cause);
    end
    repeat (4) @(negedge clock_i);
    chk(int_bits, 5'h15);
    chk(rn_coh, 8'h88);
    chk(rn_res, 8'h01);
    agent.send(12'h060, {4'h9, 60'h0_0003_0000});
    agent.idle();
    repeat (8) @(negedge clock_i);
    chk(int_bits, 5'h14);
    agent.complete(3'h3, 2'h2);
    agent.complete(3'h0, 2'h3);
    repeat (6) @(negedge clock_i);
    chk({rn_coh, rn_res, int_bits}, {8'h80, 8'h00, 5'h14});
    agent.send(12'h100, {4'h1, 60'h1});
    agent.send(12'h240, {4'h2, 60'h2});
    agent.idle();
    wait_req();
    chk(req_rn, 3'h1);
    @(negedge clock_i);
    chk({req_valid, req_rn}, {1'b1, 3'h2});
    @(posedge clock_i);
    own_req <= 1'b1;
    agent.give_bus();
    repeat (8) @(negedge clock_i);
    chk(slave, 1'b0);
    agent.send(12'h400, {4'h4, 60'h4});
    agent.idle();
    repeat (8) begin
      @(negedge clock_i);
      chk(req_valid, 1'b0);
    end
    chk({req_valid, rn_coh[4]}, 2'b00);
    @(posedge clock_i);
    own_req <= 1'b0;
    agent.take_bus(ok);
    chk({ok, slave}, 2'b11);
    tally_and_finish();
  end
endmodule : exrq_slave_bench
